// file: bid_top.sv
// Binary input conditioning: comparator source select, threshold settings,
// sampling, per-input deglitch, debounce and pulse counting, register port.
// Assumes comparator results are synchronous to clock_i, and that the
// comparator front end turns thresh_code_o and range_hi_o into a voltage.
`timescale 1ns/10ps
`include "bid_consts.svh"
module bid_top
    import bid_pkg::*;
#(
    parameter int NUM_CH = 10,
    parameter int TIME_W = 8,
    parameter int CNT_W = 16
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    input wire logic [NUM_CH-1:0] wet_cmp_i,
    input wire logic [NUM_CH-1:0] dry_cmp_i,
    output logic [NUM_CH-1:0] dry_sel_o,
    output logic [NUM_CH-1:0] range_hi_o,
    output logic [NUM_CH*10-1:0] thresh_code_o,
    output logic [NUM_CH-1:0] level_o
);
    // Timing derived from clock and sample period, threshold code limits from the mV figures
    localparam int TICK_CYC = `BID_SAMPLE_PERIOD_NS / `BID_CLK_PERIOD_NS;
    localparam int MAX_TICKS = (`BID_FILT_MAX_US * 1000) / `BID_SAMPLE_PERIOD_NS;
    localparam int THR_LO_MAX = `BID_THR_LO_MAX_MV / `BID_THR_LO_STEP_MV;
    localparam int THR_HI_MAX =
        (`BID_THR_HI_MAX_MV - `BID_THR_LO_MAX_MV) / `BID_THR_HI_STEP_MV;
    localparam logic [TIME_W-1:0] MAX_TIME = TIME_W'(MAX_TICKS);

    ////////////////////////////////////////////////////////////////////////
    // Elaboration checks
    if (NUM_CH < 1 || NUM_CH > 12 || NUM_CH > CNT_W + 16) begin : g_bad_ch
        $error("NUM_CH must be 1 to 12 to fit the address map");
    end
    if ((1 << TIME_W) - 1 < MAX_TICKS || TIME_W > 32) begin : g_bad_time
        $error("TIME_W too narrow for the longest filter time");
    end
    if (CNT_W < 1 || CNT_W > 32) begin : g_bad_cnt
        $error("CNT_W must be 1 to 32");
    end

    ////////////////////////////////////////////////////////////////////////
    // Helpers for the write decode; ch_addr also serves the read decode
    function automatic bid_addr_t ch_addr(input int ch, input bid_addr_t ofs);
        ch_addr = 8'(`BID_CH_BASE + ch * `BID_CH_STRIDE + ofs);
    endfunction : ch_addr

    // Times beyond the longest filter time are cut back to it
    function automatic logic [TIME_W-1:0] clamp_time(input logic [31:0] w);
        clamp_time = (w > 32'(MAX_TICKS)) ? MAX_TIME : w[TIME_W-1:0];
    endfunction : clamp_time

    // Codes beyond the end of the selected range are cut back to it
    function automatic bid_thr_t clamp_thr(input logic [31:0] w, input logic hi);
        int lim;
        lim = hi ? THR_HI_MAX : THR_LO_MAX;
        clamp_thr = (w > 32'(lim)) ? 10'(lim) : w[9:0];
    endfunction : clamp_thr

    ////////////////////////////////////////////////////////////////////////
    // Sample tick divider: one pulse each sample period
    logic [15:0] div_q;
    logic tick_q;
    logic smp_q;
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            div_q <= 16'h0000;
            tick_q <= 1'b0;
        end else if (div_q == 16'(TICK_CYC - 1)) begin
            div_q <= 16'h0000;
            tick_q <= 1'b1;
        end else begin
            div_q <= div_q + 16'h0001;
            tick_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Input sampling with per-input source select
    logic [NUM_CH-1:0] raw_q;
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            raw_q <= '0;
            smp_q <= 1'b0;
        end else begin
            smp_q <= tick_q; // Filters run one cycle after sampling
            if (tick_q) begin
                for (int i = 0; i < NUM_CH; i++) begin
                    raw_q[i] <= (bid_mode_t'(dry_sel_o[i]) == BID_DRY) ?
                        dry_cmp_i[i] : wet_cmp_i[i];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Configuration registers written by software
    logic [NUM_CH*TIME_W-1:0] dgl_q;
    logic [NUM_CH*TIME_W-1:0] dbn_q;
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            dry_sel_o <= {NUM_CH{`BID_RST_MODE}};
            range_hi_o <= {NUM_CH{`BID_RST_RANGE}};
        end else if (wr_i && addr_i == `BID_OFS_MODE) begin
            dry_sel_o <= wdata_i[NUM_CH-1:0];
        end else if (wr_i && addr_i == `BID_OFS_RANGE) begin
            range_hi_o <= wdata_i[NUM_CH-1:0];
        end
    end

    // Threshold code: low range counts 50 mV, high range 500 mV above 20 V
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            thresh_code_o <= {NUM_CH{`BID_RST_THR}};
        end else if (wr_i) begin
            for (int i = 0; i < NUM_CH; i++) begin
                if (addr_i == ch_addr(i, `BID_OFS_THR)) begin
                    thresh_code_o[i*10 +: 10] <= clamp_thr(wdata_i, range_hi_o[i]);
                end
            end
        end
    end

    // Deglitch and debounce times in sample ticks, one pair per input
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            dgl_q <= {NUM_CH{TIME_W'(`BID_RST_TIME)}};
            dbn_q <= {NUM_CH{TIME_W'(`BID_RST_TIME)}};
        end else if (wr_i) begin
            for (int i = 0; i < NUM_CH; i++) begin
                if (addr_i == ch_addr(i, `BID_OFS_DGL)) begin
                    dgl_q[i*TIME_W +: TIME_W] <= clamp_time(wdata_i);
                end
                if (addr_i == ch_addr(i, `BID_OFS_DBN)) begin
                    dbn_q[i*TIME_W +: TIME_W] <= clamp_time(wdata_i);
                end
            end
        end
    end

    // A write to a counter clears it
    logic [NUM_CH-1:0] cnt_clr;
    always_comb begin
        cnt_clr = '0;
        for (int i = 0; i < NUM_CH; i++) begin
            cnt_clr[i] = wr_i && (addr_i == ch_addr(i, `BID_OFS_CNT));
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Channels
    logic [NUM_CH*CNT_W-1:0] count;
    for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
        bid_chan #(
            .TIME_W(TIME_W),
            .CNT_W(CNT_W)
        ) i_bid_chan (
            .clock_i(clock_i),
            .rst_n_i(rst_n_i),
            .smp_i(smp_q),
            .raw_i(raw_q[g]),
            .dgl_time_i(dgl_q[g*TIME_W +: TIME_W]),
            .dbn_time_i(dbn_q[g*TIME_W +: TIME_W]),
            .cnt_clr_i(cnt_clr[g]),
            .level_o(level_o[g]),
            .count_o(count[g*CNT_W +: CNT_W])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // Read decode; unmapped addresses read zero
    logic [31:0] rd_word;
    always_comb begin
        rd_word = 32'h0000_0000;
        case (addr_i)
            `BID_OFS_LEVEL: rd_word[NUM_CH-1:0] = level_o;
            `BID_OFS_RAW: rd_word[NUM_CH-1:0] = raw_q;
            `BID_OFS_MODE: rd_word[NUM_CH-1:0] = dry_sel_o;
            `BID_OFS_RANGE: rd_word[NUM_CH-1:0] = range_hi_o;
            default: begin
                for (int i = 0; i < NUM_CH; i++) begin
                    if (addr_i == ch_addr(i, `BID_OFS_THR)) begin
                        rd_word[9:0] = thresh_code_o[i*10 +: 10];
                    end
                    if (addr_i == ch_addr(i, `BID_OFS_DGL)) begin
                        rd_word[TIME_W-1:0] = dgl_q[i*TIME_W +: TIME_W];
                    end
                    if (addr_i == ch_addr(i, `BID_OFS_DBN)) begin
                        rd_word[TIME_W-1:0] = dbn_q[i*TIME_W +: TIME_W];
                    end
                    if (addr_i == ch_addr(i, `BID_OFS_CNT)) begin
                        rd_word[CNT_W-1:0] = count[i*CNT_W +: CNT_W];
                    end
                end
            end
        endcase
    end

    // Read data stand only in the cycle after the strobe
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            rdata_o <= 32'h0000_0000;
        end else begin
            rdata_o <= rd_i ? rd_word : 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    a_tick_spacing: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        tick_q |=> !tick_q [*8])
        else $error("Sample ticks too close");
    a_filter_on_tick: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        $changed(level_o) |-> $past(smp_q))
        else $error("Filtered level moved off a sample tick");
    a_source_select: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        tick_q |=> raw_q[0] == ($past(dry_sel_o[0]) ?
            $past(dry_cmp_i[0]) : $past(wet_cmp_i[0])))
        else $error("Wrong comparator source sampled");
    a_thr_limit: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        wr_i && addr_i == `BID_CH_BASE && !range_hi_o[0] |=>
            thresh_code_o[9:0] <= 10'(THR_LO_MAX))
        else $error("Low range threshold beyond 20 V");
    a_level_read: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        rd_i && addr_i == `BID_OFS_LEVEL |=>
            rdata_o[NUM_CH-1:0] == $past(level_o))
        else $error("Level register read wrong");
    a_dgl_limit: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        wr_i && addr_i == ch_addr(0, `BID_OFS_DGL) |=>
            dgl_q[TIME_W-1:0] <= MAX_TIME)
        else $error("Deglitch time beyond 25 ms");

    c_tick_level: cover property (@(posedge clock_i) disable iff (!rst_n_i)
        smp_q ##1 $changed(level_o));
    c_dry_mode: cover property (@(posedge clock_i) disable iff (!rst_n_i)
        dry_sel_o[0] && tick_q);
endmodule : bid_top

// file: bid_consts.svh
// Constants of the binary input conditioning block: register offsets,
// reset values, limits and timing figures.
// Assumes inclusion by bare name from the design files.
`ifndef BID_CONSTS_SVH
`define BID_CONSTS_SVH

// Clock and sample timing
`define BID_CLK_PERIOD_NS 100
`define BID_SAMPLE_PERIOD_NS 100000
`define BID_FILT_MAX_US 25000

// Threshold figures in millivolts
`define BID_THR_LO_MAX_MV 20000
`define BID_THR_LO_STEP_MV 50
`define BID_THR_HI_MAX_MV 300000
`define BID_THR_HI_STEP_MV 500

// Global register byte offsets
`define BID_OFS_LEVEL 8'h00
`define BID_OFS_RAW 8'h04
`define BID_OFS_MODE 8'h08
`define BID_OFS_RANGE 8'h0c

// Per-channel block: base, stride and offsets inside it
`define BID_CH_BASE 8'h40
`define BID_CH_STRIDE 8'h10
`define BID_OFS_THR 8'h00
`define BID_OFS_DGL 8'h04
`define BID_OFS_DBN 8'h08
`define BID_OFS_CNT 8'h0c

// Reset values
`define BID_RST_MODE 1'b0
`define BID_RST_RANGE 1'b0
`define BID_RST_THR 10'h000
`define BID_RST_TIME 8'h00

`endif

// file: bid_pkg.sv
// Types shared by the binary input conditioning block.
// Assumes nothing of its surroundings.
package bid_pkg;
    // Register address
    typedef logic [7:0] bid_addr_t;
    // Comparator source of one input
    typedef enum logic {BID_WET, BID_DRY} bid_mode_t;
    // Threshold code
    typedef logic [9:0] bid_thr_t;
endpackage : bid_pkg

// file: bid_chan.sv
// One binary input channel: deglitch, debounce and pulse counter.
// Assumes raw_i is already sampled and smp_i pulses once per sample tick.
`timescale 1ns/10ps
`include "bid_consts.svh"
module bid_chan
    import bid_pkg::*;
#(
    parameter int TIME_W = 8,
    parameter int CNT_W = 16
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic smp_i,
    input wire logic raw_i,
    input wire logic [TIME_W-1:0] dgl_time_i,
    input wire logic [TIME_W-1:0] dbn_time_i,
    input wire logic cnt_clr_i,
    output logic level_o,
    output logic [CNT_W-1:0] count_o
);
    logic dgl_q;
    logic dgl_d;
    logic [TIME_W-1:0] run_q;
    logic [TIME_W-1:0] hold_q;
    logic rise;

    ////////////////////////////////////////////////////////////////////////
    // Deglitch: a level is accepted only after it stood for the full time;
    // the next level is formed here so the debouncer sees it in the same
    // tick and a bypassed stage adds no sample period of delay
    always_comb begin
        dgl_d = dgl_q;
        if (dgl_time_i == '0) begin
            dgl_d = raw_i;
        end else if (raw_i != dgl_q && run_q + 1'b1 >= dgl_time_i) begin
            // Edge is reported on the dgl_time_i-th sample in a row that shows it, giving the dead time
            dgl_d = raw_i;
        end
    end

    // Qualification run length; any return or acceptance restarts it
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            dgl_q <= 1'b0;
            run_q <= '0;
        end else if (smp_i) begin
            dgl_q <= dgl_d;
            if (dgl_time_i != '0 && raw_i != dgl_q && run_q + 1'b1 < dgl_time_i) begin
                run_q <= run_q + 1'b1;
            end else begin
                run_q <= '0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Debounce on the deglitched level: first change passes, then holds
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            level_o <= 1'b0;
            hold_q <= '0;
        end else if (smp_i) begin
            if (hold_q != '0) begin
                hold_q <= hold_q - 1'b1;
            end else if (dgl_d != level_o) begin
                level_o <= dgl_d;
                hold_q <= (dbn_time_i == '0) ? '0 : dbn_time_i - 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pulse counter on rising filtered edges; a clear and an edge in one cycle leave a count of one
    assign rise = smp_i && (hold_q == '0) && dgl_d && !level_o;
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            count_o <= '0;
        end else if (cnt_clr_i) begin
            count_o <= rise ? CNT_W'(1) : '0;
        end else if (rise) begin
            count_o <= count_o + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    a_dgl_bypass: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        smp_i && dgl_time_i == '0 |=> dgl_q == $past(raw_i))
        else $error("Deglitch bypass did not follow input");
    a_dgl_dead_time: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        smp_i && raw_i != dgl_q && run_q == '0 && dgl_time_i > 1 |=> $stable(dgl_q))
        else $error("Deglitch accepted a level too early");
    a_dgl_on_tick: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        $changed(dgl_q) |-> $past(smp_i) && dgl_q == $past(raw_i))
        else $error("Deglitch changed off a sample tick");
    a_dbn_first_edge: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        smp_i && hold_q == '0 && dgl_d != level_o |=> level_o == $past(dgl_d))
        else $error("Debounce did not pass first change");
    a_dbn_hold: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        hold_q != '0 |=> $stable(level_o))
        else $error("Debounce output moved during hold");
    a_dbn_source: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        $changed(level_o) |-> level_o == dgl_q)
        else $error("Debounce not fed from deglitch");
    a_cnt_rise: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        $rose(level_o) && !$past(cnt_clr_i) |-> count_o == $past(count_o) + 1'b1)
        else $error("Counter missed a rising edge");

    c_dgl_accept: cover property (@(posedge clock_i) disable iff (!rst_n_i)
        smp_i && dgl_time_i > 1 ##1 $changed(dgl_q));
    c_dbn_restart: cover property (@(posedge clock_i) disable iff (!rst_n_i)
        smp_i && hold_q == '0 && dgl_d != level_o && dbn_time_i != '0);
    c_cnt_clear_edge: cover property (@(posedge clock_i) disable iff (!rst_n_i)
        cnt_clr_i && rise);
endmodule : bid_chan

// file: bid_contacts.sv
// Model of the relay contacts and voltage sources wired to the ten inputs.
// Assumes the bench sets the wanted source states right after a rising edge.
`timescale 1ns/10ps
module bid_contacts #(
    parameter int NUM_CH = 10
) (
    input wire logic clock_i,
    input wire logic [NUM_CH-1:0] wet_set_i,
    input wire logic [NUM_CH-1:0] dry_set_i,
    output logic [NUM_CH-1:0] wet_cmp_o,
    output logic [NUM_CH-1:0] dry_cmp_o
);
    // Comparators settle one clock after the source moves; both kinds always
    // report, so a channel on the wrong source sees conflicting levels
    always_ff @(posedge clock_i) begin
        wet_cmp_o <= wet_set_i;
        dry_cmp_o <= dry_set_i;
    end
endmodule : bid_contacts

// file: bid_top_bench.sv
// Self-checking bench of the binary input conditioning block.
// Assumes the register map and tick period of the constants header.
`timescale 1ns/10ps
`include "bid_consts.svh"
module bid_top_bench
    import bid_pkg::*;
;
    localparam int NUM_CH = 10;
    localparam int STEPS = 13;
    localparam int TICK = `BID_SAMPLE_PERIOD_NS / `BID_CLK_PERIOD_NS;
    localparam int LO_MAX = `BID_THR_LO_MAX_MV / `BID_THR_LO_STEP_MV;
    localparam int HI_MAX = (`BID_THR_HI_MAX_MV - `BID_THR_LO_MAX_MV) / `BID_THR_HI_STEP_MV;
    localparam int T_MAX = `BID_FILT_MAX_US * 1000 / `BID_SAMPLE_PERIOD_NS;
    logic clock_i = 1'b0;
    logic rst_n_i = 1'b0;
    bid_addr_t addr = '0;
    logic [31:0] wdata = '0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata;
    logic [NUM_CH-1:0] wet_set = '0;
    logic [NUM_CH-1:0] dry_set = '0;
    logic [NUM_CH-1:0] wet_cmp, dry_cmp, dry_sel, range_hi, level;
    logic [NUM_CH*10-1:0] thr_code;
    int failures = 0;
    int checks = 0;
    int cyc = 0;
    // Source states per channel, bit k set at the middle of interval k
    logic [12:0] wet_tab [0:NUM_CH-1] = '{13'b0000000011111, 13'b1111111110011,
        13'b1111110000001, 13'b1111110111001, 13'b0001100110011, 13'b1111111111111,
        13'b0, 13'b0, 13'b0, 13'b0};
    logic [12:0] dry_tab [0:NUM_CH-1] = '{13'b0, 13'b0, 13'b0, 13'b0, 13'b0,
        13'b1111111111100, 13'b1111111111111, 13'b0, 13'b0, 13'b0};
    // Filtered levels expected at the middle of interval k
    logic [12:0] exp_tab [0:NUM_CH-1] = '{13'b0000000111110, 13'b1111110000000,
        13'b1111000011110, 13'b1111111100000, 13'b0011001100110, 13'b1111111111000,
        13'b0, 13'b0, 13'b0, 13'b0};
    int cnt_exp [0:NUM_CH-1] = '{1, 1, 2, 1, 3, 1, 0, 0, 0, 0};

    ////////////////////////////////////////////////////////////////////////
    // Clock, cycle count since release, design and partner
    always #50 clock_i = ~clock_i;
    always @(posedge clock_i) begin
        if (!rst_n_i) begin
            cyc <= 0;
        end else begin
            cyc <= cyc + 1;
        end
    end
    bid_top i_bid_top (.clock_i(clock_i), .rst_n_i(rst_n_i), .addr_i(addr),
        .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .wet_cmp_i(wet_cmp),
        .dry_cmp_i(dry_cmp), .dry_sel_o(dry_sel), .range_hi_o(range_hi),
        .thresh_code_o(thr_code), .level_o(level));
    bid_contacts i_bid_contacts (.clock_i(clock_i), .wet_set_i(wet_set),
        .dry_set_i(dry_set), .wet_cmp_o(wet_cmp), .dry_cmp_o(dry_cmp));

    ////////////////////////////////////////////////////////////////////////
    // Comparison, register access and pacing
    task automatic give_verdict();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : give_verdict
    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, e, g);
        end
    endtask : chk
    function automatic bid_addr_t ch_reg(input int ch, input bid_addr_t ofs);
        return bid_addr_t'(`BID_CH_BASE + ch * `BID_CH_STRIDE + ofs);
    endfunction : ch_reg
    task automatic wr_reg(input bid_addr_t a, input logic [31:0] d);
        @(posedge clock_i);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock_i);
        wr <= 1'b0;
    endtask : wr_reg
    // Read data stand only in the cycle after the strobe
    task automatic rd_chk(input string what, input bid_addr_t a, input logic [31:0] e);
        @(posedge clock_i);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock_i);
        rd <= 1'b0;
        @(negedge clock_i);
        chk(what, e, rdata);
    endtask : rd_chk
    // Middle of interval k keeps every drive and check clear of the tick
    task automatic goto_mid(input int k);
        int n;
        n = 0;
        while (cyc < k * TICK + TICK / 2) begin
            @(posedge clock_i);
            n++;
            if (n > 4 * TICK) begin
                failures++;
                $display("mismatch wait for step %0d expected reached seen timeout", k);
                give_verdict();
            end
        end
    endtask : goto_mid

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        logic [31:0] ev;
        repeat (10) @(posedge clock_i);
        rst_n_i <= 1'b1;
        @(negedge clock_i);
        chk("dry_sel_o", 32'h0, 32'(dry_sel));
        chk("range_hi_o", 32'h0, 32'(range_hi));
        chk("thresh_code_o", 32'h0, 32'(|thr_code));
        rd_chk("mode", `BID_OFS_MODE, 32'h0);
        rd_chk("dbn ch9", ch_reg(9, `BID_OFS_DBN), 32'h0);
        wr_reg(`BID_OFS_RANGE, 32'h082);
        rd_chk("range", `BID_OFS_RANGE, 32'h082);
        chk("range_hi_o", 32'h082, 32'(range_hi));
        wr_reg(ch_reg(0, `BID_OFS_THR), 32'd401);
        wr_reg(ch_reg(1, `BID_OFS_THR), 32'd600);
        wr_reg(ch_reg(7, `BID_OFS_THR), 32'd401);
        rd_chk("thr ch0", ch_reg(0, `BID_OFS_THR), 32'(LO_MAX));
        rd_chk("thr ch1", ch_reg(1, `BID_OFS_THR), 32'(HI_MAX));
        rd_chk("thr ch7", ch_reg(7, `BID_OFS_THR), 32'd401);
        chk("thresh_code_o ch1", 32'(HI_MAX), 32'(thr_code[10+:10]));
        wr_reg(ch_reg(9, `BID_OFS_DGL), 32'd300);
        rd_chk("dgl ch9", ch_reg(9, `BID_OFS_DGL), 32'(T_MAX));
        wr_reg(ch_reg(9, `BID_OFS_DGL), 32'd0);
        wr_reg(8'h10, 32'hffff);
        wr_reg(`BID_OFS_LEVEL, 32'h3ff);
        rd_chk("unmapped", 8'h10, 32'h0);
        rd_chk("level ro", `BID_OFS_LEVEL, 32'h0);
        wr_reg(`BID_OFS_MODE, 32'h020);
        rd_chk("mode", `BID_OFS_MODE, 32'h020);
        chk("dry_sel_o", 32'h020, 32'(dry_sel));
        wr_reg(ch_reg(1, `BID_OFS_DGL), 32'd3);
        wr_reg(ch_reg(2, `BID_OFS_DBN), 32'd4);
        wr_reg(ch_reg(3, `BID_OFS_DGL), 32'd2);
        wr_reg(ch_reg(3, `BID_OFS_DBN), 32'd3);
        rd_chk("dbn ch2", ch_reg(2, `BID_OFS_DBN), 32'd4);
        $display("test registers done");
        // Glitches, bounces, pulse trains and source choice run side by side
        for (int k = 0; k < STEPS; k++) begin
            goto_mid(k);
            ev = '0;
            for (int c = 0; c < NUM_CH; c++) begin
                ev[c] = exp_tab[c][k];
                wet_set[c] <= wet_tab[c][k];
                dry_set[c] <= dry_tab[c][k];
            end
            @(negedge clock_i);
            chk($sformatf("level_o step %0d", k), ev, 32'(level));
        end
        $display("test filters done");
        for (int c = 0; c < NUM_CH; c++) begin
            rd_chk($sformatf("count ch%0d", c), ch_reg(c, `BID_OFS_CNT), 32'(cnt_exp[c]));
        end
        rd_chk("level", `BID_OFS_LEVEL, 32'h02e);
        rd_chk("raw", `BID_OFS_RAW, 32'h02e);
        wr_reg(ch_reg(4, `BID_OFS_CNT), 32'h1);
        rd_chk("count ch4 cleared", ch_reg(4, `BID_OFS_CNT), 32'h0);
        $display("test counters done");
        give_verdict();
    end
endmodule : bid_top_bench
